// ---- common/cbr_dec_if.sv ----
// interface: opcode out to the decoder, decoded operation back
`timescale 1ns/1ps
interface cbr_dec_if;
  import cbr_pkg::*;
  logic [9:0] opcode;
  cbr_op_t op;
  logic [1:0] bit_sel;
  modport dec (input opcode, output op, bit_sel);
  modport exe (output opcode, input op, bit_sel);
endinterface : cbr_dec_if

// ---- common/cbr_pkg.sv ----
// package: opcodes, register map, field positions and reset values of the executor
package cbr_pkg;
  // ==================== opcodes (10-bit instruction words)
  localparam logic [9:0] OPC_OR_MEM = 10'h019;
  localparam logic [9:0] OPC_BKP_ENTRY = 10'h002;
  localparam logic [9:0] OPC_BKP_ARM = 10'h05b;
  localparam logic [9:0] OPC_ROT_R = 10'h01d;
  localparam logic [9:0] OPC_CLR_MBIT = 10'h04c;
  localparam logic [9:0] OPC_SET_MBIT = 10'h05c;
  localparam logic [9:0] OPC_CLR_CARRY = 10'h006;
  localparam logic [9:0] OPC_SET_CARRY = 10'h007;
  localparam logic [9:0] OPC_CLR_PBIT = 10'h014;
  localparam logic [9:0] OPC_SET_PBIT = 10'h015;
  localparam logic [9:0] OPC_SUB_RET = 10'h044;
  localparam logic [9:0] OPC_SUB_RET_SKIP = 10'h045;
  localparam logic [9:0] OPC_IRQ_RET = 10'h046;
  localparam logic [9:0] OPC_EQ_IMM = 10'h025;
  localparam logic [9:0] OPC_EQ_MEM = 10'h026;
  localparam logic [9:0] OPC_SK_EXT0 = 10'h038;
  localparam logic [9:0] OPC_SK_EXT1 = 10'h039;
  localparam logic [9:0] OPC_SK_CONV = 10'h287;
  localparam logic [9:0] OPC_SK_PIN0 = 10'h03a;
  localparam logic [9:0] OPC_SK_PIN1 = 10'h03b;
  localparam logic [9:0] OPC_SK_MARK = 10'h003;
  // ==================== register byte offsets
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_ACC = 8'h08;
  localparam logic [7:0] A_PTR = 8'h0c;
  localparam logic [7:0] A_MEM = 8'h10;
  localparam logic [7:0] A_PC = 8'h14;
  localparam logic [7:0] A_PORTD = 8'h18;
  localparam logic [7:0] A_ICTL = 8'h1c;
  localparam logic [7:0] A_FLAGS = 8'h20;
  localparam logic [7:0] A_ISTAT = 8'h24;
  localparam logic [7:0] A_IMASK = 8'h28;
  // ==================== field positions
  localparam int unsigned CTRL_CALL_BIT = 0;
  localparam int unsigned CTRL_IRQ_BIT = 1;
  localparam int unsigned ACC_CARRY_BIT = 8;
  localparam int unsigned PC_LVL_LSB = 16;
  localparam int unsigned EXT0_SKDIS_BIT = 0;
  localparam int unsigned EXT1_SKDIS_BIT = 1;
  localparam int unsigned CONV_SKDIS_BIT = 2;
  localparam int unsigned PIN_LVL_BIT = 2;
  localparam int unsigned F_EXT0 = 0;
  localparam int unsigned F_EXT1 = 1;
  localparam int unsigned F_CONV = 2;
  localparam int unsigned F_MARK = 3;
  localparam int unsigned F_BKP = 4;
  // ==================== reset values and bus answers
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [7:0] RST_PORTD = 8'h00;
  localparam logic [15:0] RST_ICTL = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==================== types
  typedef enum logic [4:0] {
    OP_NONE, OP_OR_MEM, OP_BKP_ARM, OP_BKP_ENTRY, OP_ROT_R, OP_CLR_MBIT, OP_SET_MBIT,
    OP_CLR_CARRY, OP_SET_CARRY, OP_CLR_PBIT, OP_SET_PBIT, OP_SUB_RET, OP_SUB_RET_SKIP,
    OP_IRQ_RET, OP_EQ_IMM, OP_EQ_MEM, OP_SK_EXT0, OP_SK_EXT1, OP_SK_CONV, OP_SK_PIN0,
    OP_SK_PIN1, OP_SK_MARK
  } cbr_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RET2, ST_WAIT2} cbr_state_t;
endpackage : cbr_pkg

// ---- hdl/cbr_decode.sv ----
// module: instruction word decoder for the executor
`timescale 1ns/1ps
module cbr_decode import cbr_pkg::*; (
  cbr_dec_if.dec bus
);
  // ====================
  // decode table
  function automatic cbr_op_t decode(input logic [9:0] w);
    cbr_op_t o;
    o = OP_NONE;
    case (w)
      OPC_OR_MEM: o = OP_OR_MEM;
      OPC_BKP_ENTRY: o = OP_BKP_ENTRY;
      OPC_BKP_ARM: o = OP_BKP_ARM;
      OPC_ROT_R: o = OP_ROT_R;
      OPC_CLR_CARRY: o = OP_CLR_CARRY;
      OPC_SET_CARRY: o = OP_SET_CARRY;
      OPC_CLR_PBIT: o = OP_CLR_PBIT;
      OPC_SET_PBIT: o = OP_SET_PBIT;
      OPC_SUB_RET: o = OP_SUB_RET;
      OPC_SUB_RET_SKIP: o = OP_SUB_RET_SKIP;
      OPC_IRQ_RET: o = OP_IRQ_RET;
      OPC_EQ_IMM: o = OP_EQ_IMM;
      OPC_EQ_MEM: o = OP_EQ_MEM;
      OPC_SK_EXT0: o = OP_SK_EXT0;
      OPC_SK_EXT1: o = OP_SK_EXT1;
      OPC_SK_CONV: o = OP_SK_CONV;
      OPC_SK_PIN0: o = OP_SK_PIN0;
      OPC_SK_PIN1: o = OP_SK_PIN1;
      OPC_SK_MARK: o = OP_SK_MARK;
      default: begin
        // bit ops carry the bit number in the two low opcode bits
        if (w[9:2] == OPC_CLR_MBIT[9:2]) o = OP_CLR_MBIT;
        else if (w[9:2] == OPC_SET_MBIT[9:2]) o = OP_SET_MBIT;
      end
    endcase
    return o;
  endfunction : decode

  assign bus.op = decode(bus.opcode);
  assign bus.bit_sel = bus.opcode[1:0];
endmodule : cbr_decode

// ---- hdl/cbr_exec_top.sv ----
// module: AXI4-Lite driven executor for bit, skip and return instructions
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Function
// [RULE1] or-memory op: acc becomes acc OR nibble at pointer, one cycle
// [RULE2] backup entry op enters backup mode only right after arm op, else no-op
// [RULE3] rotate right: old carry to acc bit 3, acc bit 0 to carry
// [RULE4] memory bit ops clear or set bit 0..3 of nibble at pointer
// [RULE5] carry clear and set ops force carry to 0 or 1
// [RULE6] port bit ops clear or set port D bit indexed by Y (0..7)
// [RULE7] subroutine returns take two cycles, pop pc; skipping variant always skips
// [RULE8] interrupt return pops pc in one cycle and restores saved state
// [RULE9] compare-immediate is two words; skips when acc equals immediate
// [RULE10] compare-memory skips when acc equals nibble at pointer
// [RULE11] ext0 skip: if enabled and flag set, skip and clear flag
// [RULE12] ext1 skip: if enabled and flag set, skip and clear flag
// [RULE13] conversion skip: if enabled and done flag set, skip and clear it
// [RULE14] pin0 skip when pin level matches its level select bit
// [RULE15] pin1 skip when pin level matches its level select bit
// [RULE16] mark skip skips when backup mark set, leaving the mark unchanged
module cbr_exec_top import cbr_pkg::*; #(
  parameter int unsigned PC_W = 13,
  parameter int unsigned STK_D = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic ext_irq_pin_0,
  input logic ext_irq_pin_1,
  input logic ext0_req_set,
  input logic ext1_req_set,
  input logic conv_done_set,
  input logic backup_mark_set,
  output logic [7:0] port_d,
  output logic backup_mode,
  output logic irq
);
  localparam int unsigned LW = $clog2(STK_D);
  localparam logic [LW-1:0] LVL_RST = LW'(STK_D - 1);

  logic [3:0] acc_q, b_q, x_q, y_q, mem_rd, ist_q, imask_q;
  logic [3:0] sh_acc_q, sh_b_q, sh_x_q, sh_y_q;
  logic [1:0] z_q, sh_z_q, pin_m_q, pin_s_q;
  logic carry_q, skip_q, arm_q, bkm_q, mark_q, ef0_q, ef1_q, adf_q, sh_carry_q, sh_skip_q;
  logic [PC_W-1:0] pc_q;
  logic [LW-1:0] lvl_q;
  logic [PC_W-1:0] stk_q [STK_D];
  logic [3:0] mem_q [1024];
  logic [7:0] pd_q;
  logic [15:0] ictl_q;
  logic [9:0] last_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rv [16];
  cbr_state_t st_q;

  // ==================== pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_q <= 2'h0;
      pin_s_q <= 2'h0;
    end else begin
      pin_m_q <= {ext_irq_pin_1, ext_irq_pin_0};
      pin_s_q <= pin_m_q;
    end
  end

  // ==================== bus slave
  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : at

  function automatic logic mapped(input logic [7:0] a);
    return a[7:2] <= A_IMASK[7:2];
  endfunction : mapped

  // a subroutine return blocks bus writes for its second cycle so no word lands mid-pop
  wire wr_fire = awvalid & wvalid & ~bvalid_q & (st_q != ST_RET2);
  wire ar_fire = arvalid & ~rvalid_q;
  wire w_ok = mapped(awaddr);
  wire r_ok = mapped(araddr);
  wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [31:0] wv = (rv[awaddr[5:2]] & ~wmask) | (wdata & wmask);
  wire go = wr_fire & at(awaddr, A_INSTR);
  wire wr_ctrl = wr_fire & at(awaddr, A_CTRL);
  wire wr_acc = wr_fire & at(awaddr, A_ACC);
  wire wr_ptr = wr_fire & at(awaddr, A_PTR);
  wire wr_mem = wr_fire & at(awaddr, A_MEM);
  wire wr_pc = wr_fire & at(awaddr, A_PC);
  wire wr_pd = wr_fire & at(awaddr, A_PORTD);
  wire wr_ictl = wr_fire & at(awaddr, A_ICTL);
  wire wr_flags = wr_fire & at(awaddr, A_FLAGS);
  wire wr_imask = wr_fire & at(awaddr, A_IMASK);
  wire ist_clr = ar_fire & at(araddr, A_ISTAT);

  assign awready = wr_fire;
  assign wready = wr_fire;
  assign arready = ~rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  always_comb begin
    for (int i = 0; i < 16; i++) rv[i] = 32'h0;
    rv[0] = {22'h0, last_q};
    rv[2] = {23'h0, carry_q, b_q, acc_q};
    rv[3] = {22'h0, z_q, x_q, y_q};
    rv[4] = {28'h0, mem_rd};
    rv[5] = 32'(pc_q) | (32'(lvl_q) << PC_LVL_LSB);
    rv[6] = {24'h0, pd_q};
    rv[7] = {16'h0, ictl_q};
    rv[8] = {25'h0, st_q == ST_WAIT2, skip_q, bkm_q, mark_q, adf_q, ef1_q, ef0_q};
    rv[9] = {28'h0, ist_q};
    rv[10] = {28'h0, imask_q};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= r_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= r_ok ? rv[araddr[5:2]] : 32'h0;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==================== decode and skip conditions
  cbr_dec_if dif ();
  assign dif.opcode = wv[9:0];
  cbr_decode u_dec (.bus(dif));

  wire cbr_op_t op = dif.op;
  wire ex = go & (st_q == ST_IDLE) & ~skip_q;
  wire w2 = go & (st_q == ST_WAIT2);
  wire [9:0] ptr_idx = {z_q, x_q, y_q};
  assign mem_rd = mem_q[ptr_idx];
  wire sk_e0 = ~ictl_q[EXT0_SKDIS_BIT] & ef0_q;
  wire sk_e1 = ~ictl_q[4 + EXT1_SKDIS_BIT - 4] & ef1_q;
  wire sk_ad = ~ictl_q[4 + CONV_SKDIS_BIT] & adf_q;
  wire pin0_hit = pin_s_q[0] == ictl_q[8 + PIN_LVL_BIT];
  wire pin1_hit = pin_s_q[1] == ictl_q[12 + PIN_LVL_BIT];
  wire pop = ex & (op == OP_SUB_RET | op == OP_SUB_RET_SKIP | op == OP_IRQ_RET);
  wire do_rti = ex & (op == OP_IRQ_RET);
  wire enter_bkp = ex & (op == OP_BKP_ENTRY) & arm_q; // see [RULE2]
  wire take_irq = wr_ctrl & wv[CTRL_IRQ_BIT];
  wire push = wr_ctrl & (wv[CTRL_CALL_BIT] | wv[CTRL_IRQ_BIT]);
  wire cond_skip = (op == OP_SUB_RET_SKIP) // see [RULE7]
    | (op == OP_EQ_MEM & acc_q == mem_rd) // see [RULE10]
    | (op == OP_SK_EXT0 & sk_e0) // see [RULE11]
    | (op == OP_SK_EXT1 & sk_e1) // see [RULE12]
    | (op == OP_SK_CONV & sk_ad) // see [RULE13]
    | (op == OP_SK_PIN0 & pin0_hit) // see [RULE14]
    | (op == OP_SK_PIN1 & pin1_hit) // see [RULE15]
    | (op == OP_SK_MARK & mark_q); // see [RULE16]
  wire imm_eq = acc_q == wv[3:0]; // see [RULE9]
  wire new_skip = (ex & cond_skip) | (w2 & imm_eq);
  wire [3:0] bit_m = 4'h1 << dif.bit_sel;
  wire mem_we = wr_mem | (ex & (op == OP_CLR_MBIT | op == OP_SET_MBIT));
  wire [3:0] mem_wd = wr_mem ? wv[3:0] :
    (op == OP_SET_MBIT) ? (mem_rd | bit_m) : (mem_rd & ~bit_m); // see [RULE4]

  // ==================== sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (ex && (op == OP_SUB_RET || op == OP_SUB_RET_SKIP)) st_q <= ST_RET2; // see [RULE7]
          else if (ex && op == OP_EQ_IMM) st_q <= ST_WAIT2; // see [RULE9]
        end
        ST_RET2: st_q <= ST_IDLE;
        ST_WAIT2: if (go) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_q <= 1'b0;
      arm_q <= 1'b0;
      last_q <= 10'h000;
    end else begin
      if (take_irq) skip_q <= 1'b0;
      else if (do_rti) skip_q <= sh_skip_q; // see [RULE8]
      else if (go) skip_q <= new_skip;
      if (go) arm_q <= ex & (op == OP_BKP_ARM);
      if (go) last_q <= wv[9:0];
    end
  end

  // ==================== program counter and stack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= '0;
      lvl_q <= LVL_RST;
    end else if (pop) begin
      pc_q <= stk_q[lvl_q]; // see [RULE7] [RULE8]
      lvl_q <= lvl_q - 1'b1;
    end else if (push) begin
      lvl_q <= lvl_q + 1'b1;
    end else if (wr_pc) begin
      pc_q <= wv[PC_W-1:0];
      lvl_q <= wv[PC_LVL_LSB +: LW];
    end else if (go) begin
      pc_q <= pc_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) stk_q[lvl_q + 1'b1] <= pc_q;
  end

  always_ff @(posedge aclk) begin
    if (mem_we) mem_q[ptr_idx] <= mem_wd;
  end

  // ==================== working registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= RST_NIB;
      b_q <= RST_NIB;
      carry_q <= 1'b0;
    end else if (do_rti) begin
      acc_q <= sh_acc_q; // see [RULE8]
      b_q <= sh_b_q;
      carry_q <= sh_carry_q;
    end else if (wr_acc) begin
      acc_q <= wv[3:0];
      b_q <= wv[7:4];
      carry_q <= wv[ACC_CARRY_BIT];
    end else if (ex) begin
      if (op == OP_OR_MEM) acc_q <= acc_q | mem_rd; // see [RULE1]
      if (op == OP_ROT_R) begin
        acc_q <= {carry_q, acc_q[3:1]}; // see [RULE3]
        carry_q <= acc_q[0];
      end
      if (op == OP_CLR_CARRY) carry_q <= 1'b0; // see [RULE5]
      if (op == OP_SET_CARRY) carry_q <= 1'b1; // see [RULE5]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {z_q, x_q, y_q} <= 10'h000;
    end else if (do_rti) begin
      {z_q, x_q, y_q} <= {sh_z_q, sh_x_q, sh_y_q}; // see [RULE8]
    end else if (wr_ptr) begin
      {z_q, x_q, y_q} <= wv[9:0];
    end
  end

  // snapshot only on interrupt entry; a plain call leaves it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sh_acc_q, sh_b_q, sh_x_q, sh_y_q, sh_z_q} <= 18'h00000;
      {sh_carry_q, sh_skip_q} <= 2'h0;
    end else if (take_irq) begin
      {sh_acc_q, sh_b_q, sh_x_q, sh_y_q, sh_z_q} <= {acc_q, b_q, x_q, y_q, z_q};
      {sh_carry_q, sh_skip_q} <= {carry_q, skip_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_q <= RST_PORTD;
      ictl_q <= RST_ICTL;
    end else begin
      if (wr_pd) pd_q <= wv[7:0];
      else if (ex && !y_q[3] && (op == OP_CLR_PBIT || op == OP_SET_PBIT))
        pd_q[y_q[2:0]] <= op == OP_SET_PBIT; // see [RULE6]
      if (wr_ictl) ictl_q <= wv[15:0];
    end
  end

  // ==================== request flags: a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ef0_q, ef1_q, adf_q, mark_q, bkm_q} <= 5'h00;
    end else begin
      ef0_q <= ext0_req_set | (wr_flags ? wv[F_EXT0] : ef0_q & ~(ex & op == OP_SK_EXT0 & sk_e0)); // see [RULE11]
      ef1_q <= ext1_req_set | (wr_flags ? wv[F_EXT1] : ef1_q & ~(ex & op == OP_SK_EXT1 & sk_e1)); // see [RULE12]
      adf_q <= conv_done_set | (wr_flags ? wv[F_CONV] : adf_q & ~(ex & op == OP_SK_CONV & sk_ad)); // see [RULE13]
      mark_q <= backup_mark_set | (wr_flags ? wv[F_MARK] : mark_q); // see [RULE16]
      bkm_q <= enter_bkp | (wr_flags ? wv[F_BKP] & bkm_q : bkm_q); // see [RULE2]
    end
  end

  // ==================== interrupt status
  wire [3:0] ev = {ex & (op == OP_NONE), pop, enter_bkp, new_skip};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= 4'h0;
      imask_q <= 4'h0;
    end else begin
      ist_q <= ev | (ist_clr ? 4'h0 : ist_q);
      if (wr_imask) imask_q <= wv[3:0];
    end
  end

  assign irq = |(ist_q & imask_q);
  assign port_d = pd_q;
  assign backup_mode = bkm_q;
  // ==================== assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ret_pop;
    st_q == ST_RET2 ##1 st_q == ST_IDLE;
  endsequence
  or_acc_a: assert property (ex && op == OP_OR_MEM && !wr_acc |=> // see [RULE1]
    acc_q == ($past(acc_q) | $past(mem_rd))) else $error("or result wrong");
  backup_gate_a: assert property (ex && op == OP_BKP_ENTRY |=> // see [RULE2]
    backup_mode == $past(bkm_q || arm_q)) else $error("backup entry gate wrong");
  rotate_right_a: assert property (ex && op == OP_ROT_R |=> // see [RULE3]
    {acc_q, carry_q} == {$past(carry_q), $past(acc_q)}) else $error("rotate wrong");
  mem_bit_a: assert property (ex && op == OP_SET_MBIT |=> // see [RULE4]
    mem_rd[$past(dif.bit_sel)]) else $error("memory bit not set");
  carry_force_a: assert property (ex && (op == OP_SET_CARRY || op == OP_CLR_CARRY) // see [RULE5]
    |=> carry_q == $past(op == OP_SET_CARRY)) else $error("carry not forced");
  port_bit_a: assert property (ex && !y_q[3] && op == OP_SET_PBIT |=> // see [RULE6]
    port_d[$past(y_q[2:0])]) else $error("port bit not set");
  ret_two_a: assert property (ex && op == OP_SUB_RET_SKIP |=> s_ret_pop and skip_q) // see [RULE7]
    else $error("return sequence wrong");
  irq_ret_a: assert property (ex && op == OP_IRQ_RET |=> acc_q == $past(sh_acc_q) // see [RULE8]
    && lvl_q == $past(lvl_q) - 1'b1 && st_q == ST_IDLE) else $error("irq return wrong");
  imm_cmp_a: assert property (ex && op == OP_EQ_IMM |=> st_q == ST_WAIT2 && !skip_q) // see [RULE9]
    else $error("compare did not wait for operand");
  ext0_clear_a: assert property (ex && op == OP_SK_EXT0 && sk_e0 && !ext0_req_set |=> // see [RULE11]
    skip_q && !ef0_q) else $error("ext0 skip wrong");
  pin0_level_a: assert property (ex && op == OP_SK_PIN0 |=> skip_q == $past(pin0_hit)) // see [RULE14]
    else $error("pin0 skip wrong");
  mark_keep_a: assert property (ex && op == OP_SK_MARK |=> skip_q == $past(mark_q) // see [RULE16]
    && (mark_q || !$past(mark_q))) else $error("mark skip wrong");
endmodule : cbr_exec_top

// ---- tb/cbr_exec_top_test.sv ----
// testbench: random and corner-case runs of the bit, skip and return executor
`timescale 1ns/1ps
module cbr_exec_top_test;
  import cbr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  // responses are always accepted at once, so ready never toggles
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic [1:0] pin = 2'h0;
  logic [3:0] setp = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, backup_mode, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rv;
  logic [7:0] port_d, seed;
  logic [9:0] skop [3] = '{OPC_SK_EXT0, OPC_SK_EXT1, OPC_SK_CONV};
  logic [9:0] rop [3] = '{OPC_SUB_RET, OPC_SUB_RET_SKIP, OPC_IRQ_RET};
  int dbit [3] = '{0, 1, 6};
  int mismatches = 0;
  int checks_done = 0;
  always #50 aclk = ~aclk;
  cbr_exec_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_irq_pin_0(pin[0]), .ext_irq_pin_1(pin[1]), .ext0_req_set(setp[0]),
    .ext1_req_set(setp[1]), .conv_done_set(setp[2]), .backup_mark_set(setp[3]),
    .port_d(port_d), .backup_mode(backup_mode), .irq(irq));
  // ==========
  // helpers
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic hang();
    mismatches++;
    $display("[ERR] handshake expected 1 seen 0");
    wrap_up();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge aclk);
    while (!(awready === 1'b1 && wready === 1'b1)) begin
      n++;
      if (n > 50) hang();
      @(posedge aclk);
    end
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) begin
      n++;
      if (n > 100) hang();
      @(posedge aclk);
    end
    rsp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) begin
      n++;
      if (n > 50) hang();
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) begin
      n++;
      if (n > 100) hang();
      @(posedge aclk);
    end
    rv = rdata;
    rsp = rresp;
  endtask : rd
  task automatic ex(input logic [9:0] op);
    wr(A_INSTR, {22'h0, op});
  endtask : ex
  // a skip discards the carry set, so carry shows whether it was taken
  task automatic trial(input logic [9:0] op);
    ex(op);
    ex(OPC_SET_CARRY);
  endtask : trial
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string w);
    rd(a);
    chk(w, e, rv & m);
  endtask : rdc
  task automatic pulse(input int k);
    setp <= 4'h1 << k;
    @(posedge aclk);
    setp <= 4'h0;
    @(posedge aclk);
  endtask : pulse
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [31:0] ror_exp(input logic [31:0] v);
    return {23'h0, v[0], 4'h0, v[8], v[3:1]};
  endfunction : ror_exp
  function automatic logic [31:0] cy(input logic c);
    return {23'h0, c, 8'h0};
  endfunction : cy
  // ==========
  // main sequence
  initial begin
    logic [31:0] a, m;
    int k;
    seed = 8'h0c;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = {23'h0, seed[0], 4'h0, seed[7:4]};
      seed = lfsr(seed);
      m = {28'h0, seed[3:0]};
      wr(A_PTR, {24'h0, seed});
      wr(A_MEM, m);
      wr(A_ACC, a);
      ex(OPC_OR_MEM);
      rdc(A_ACC, 32'h1ff, a | m, "or mem");
      wr(A_ACC, a);
      ex(OPC_ROT_R);
      rdc(A_ACC, 32'h1ff, ror_exp(a), "rotate");
      ex(OPC_SET_MBIT | 10'(i % 4));
      m[i % 4] = 1'b1;
      ex(OPC_CLR_MBIT | 10'((i + 1) % 4));
      m[(i + 1) % 4] = 1'b0;
      rdc(A_MEM, 32'hf, m, "mem bits");
      a[8] = 1'b0;
      if (i[0]) a[3:0] = m[3:0];
      wr(A_ACC, a);
      trial(OPC_EQ_MEM);
      rdc(A_ACC, 32'h100, cy(a[3:0] != m[3:0]), "eq mem");
      k = i[1] ? int'(a[3:0]) : (i == 0 ? 15 : int'(seed[7:4]));
      wr(A_ACC, a);
      ex(OPC_EQ_IMM);
      trial(10'h070 | 10'(k));
      rdc(A_ACC, 32'h100, cy(a[3:0] != 4'(k)), "eq imm");
    end
    $display("end of alu and compare test");
    for (int y = 0; y < 9; y++) begin
      wr(A_PTR, 32'(y));
      ex(OPC_SET_PBIT);
      chk("port set", {24'h0, 8'(9'h1 << y)}, {24'h0, port_d});
      ex(OPC_CLR_PBIT);
      chk("port clr", 32'h0, {24'h0, port_d});
    end
    ex(OPC_SET_CARRY);
    rdc(A_ACC, 32'h100, 32'h100, "carry set");
    ex(OPC_CLR_CARRY);
    rdc(A_ACC, 32'h100, 32'h0, "carry clr");
    $display("end of port and carry test");
    for (int f = 0; f < 6; f++) begin
      wr(A_ICTL, 32'(f / 3) << dbit[f % 3]);
      pulse(f % 3);
      trial(skop[f % 3]);
      rdc(A_ACC, 32'h100, cy(f >= 3), "flag skip");
      rdc(A_FLAGS, 32'h7, f < 3 ? 32'h0 : 32'h1 << (f % 3), "flag kept");
      ex(OPC_CLR_CARRY);
      wr(A_FLAGS, 32'h0);
    end
    for (int q = 0; q < 8; q++) begin
      pin <= {q[0], q[0]};
      wr(A_ICTL, 32'(q[1]) << (q[2] ? 14 : 10));
      trial(q[2] ? OPC_SK_PIN1 : OPC_SK_PIN0);
      rdc(A_ACC, 32'h100, cy(q[0] != q[1]), "pin skip");
      ex(OPC_CLR_CARRY);
    end
    trial(OPC_SK_MARK);
    rdc(A_ACC, 32'h100, 32'h100, "mark off");
    ex(OPC_CLR_CARRY);
    pulse(3);
    trial(OPC_SK_MARK);
    rdc(A_ACC, 32'h100, 32'h0, "mark skip");
    rdc(A_FLAGS, 32'h8, 32'h8, "mark kept");
    $display("end of skip test");
    ex(OPC_BKP_ENTRY);
    ex(OPC_BKP_ARM);
    ex(OPC_CLR_CARRY);
    ex(OPC_BKP_ENTRY);
    chk("no backup", 32'h0, {31'h0, backup_mode});
    ex(OPC_BKP_ARM);
    ex(OPC_BKP_ENTRY);
    chk("backup", 32'h1, {31'h0, backup_mode});
    // status holds skip bits here, but the mask still hides them
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_IMASK, 32'h4);
    rd(A_ISTAT);
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      wr(A_PC, {13'h0, 3'h2, 3'h0, 5'h0, seed});
      wr(A_ACC, 32'h0a5);
      wr(A_CTRL, r == 2 ? 32'h2 : 32'h1);
      wr(A_PC, {13'h0, 3'h3, 3'h0, 13'h1fff});
      wr(A_ACC, 32'h10f);
      ex(rop[r]);
      rdc(A_PC, 32'h71fff, {13'h0, 3'h2, 3'h0, 5'h0, seed}, "pop pc");
      rdc(A_ACC, 32'h1ff, r == 2 ? 32'h0a5 : 32'h10f, "restore");
      rdc(A_FLAGS, 32'h20, r == 1 ? 32'h20 : 32'h0, "ret skip");
      chk("irq", 32'h1, {31'h0, irq});
      rdc(A_ISTAT, 32'h4, 32'h4, "ret status");
      chk("irq clr", 32'h0, {31'h0, irq});
      if (r == 1) ex(OPC_CLR_CARRY);
    end
    wr(8'h40, 32'h1);
    chk("bad wr", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd(8'hfc);
    chk("bad rd", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("bad data", 32'h0, rv);
    $display("end of return and bus test");
    wrap_up();
  end
endmodule : cbr_exec_top_test
